//--- data_island_packet_buffer.sv
`timescale 1ns/1ps
module data_island_packet_buffer
    import dip_pkg::*;
#(
    parameter int unsigned NUM_BUFS = BUF_COUNT
) (
    input  wire logic                     sys_clk,
    input  wire logic                     rst_n,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    input  wire logic [3:0]               reg_addr,
    input  wire logic [31:0]              reg_wdata,
    output logic      [31:0]              reg_rdata,
    output logic                          reg_ack,
    input  wire logic                     port_is_dp,
    input  wire logic [2:0]               pixel_depth,
    input  wire logic                     tx_rd,
    input  wire logic [1:0]               tx_buf,
    input  wire logic [3:0]               tx_word,
    output logic      [31:0]              tx_data,
    input  wire logic                     gcp_sent,
    output logic      [23:0]              gcp_payload,
    output logic                          control_packet_enable,
    output logic      [3:0]               packet_type_enables,
    output logic      [NUM_BUFS-1:0][1:0] resend_rates
);

    if (NUM_BUFS != BUF_COUNT) begin : g_chk
        $error("buffer count must match the two-bit select");
    end

    logic [NUM_BUFS-1:0][STORED_WORDS-1:0][31:0] mem_r,  mem_nxt;
    logic [NUM_BUFS-1:0][ECC_BYTES-1:0][7:0]     ecc_all;
    logic [NUM_BUFS-1:0][7:0]                    hdr_ecc_all;
    logic [NUM_BUFS-1:0][1:0]                    rate_r, rate_nxt;
    logic                                        gcp_en_r, gcp_en_nxt;
    logic [3:0]                                  type_en_r, type_en_nxt;
    logic [1:0]                                  sel_r, sel_nxt;
    logic [3:0]                                  ptr_r, ptr_nxt;
    logic [1:0]                                  rate_pend_r, rate_pend_nxt;
    logic [2:0]                                  gcp_r, gcp_nxt;
    mute_state_t                                 mute_r, mute_nxt;
    logic [31:0]                                 rdata_r, rdata_nxt;
    logic                                        ack_r, ack_nxt;
    logic [31:0]                                 tx_data_r, tx_data_nxt;
    logic [23:0]                                 pay_r, pay_nxt;
    logic                                        ctl_wr;
    logic                                        data_wr;
    logic                                        data_rd;
    logic                                        gcp_wr;
    logic                                        data_acc;

    // one parity generator per buffer keeps every ECC word current for reads
    for (genvar g = 0; g < NUM_BUFS; g++) begin : g_ecc
        ecc_if eif ();
        assign eif.words      = mem_r[g];
        assign ecc_all[g]     = eif.ecc;
        assign hdr_ecc_all[g] = eif.hdr_ecc;
        ecc_gen u_ecc (
            .pkt (eif)
        );
    end

    // no byte lanes exist on this port: every access is a whole dword
    assign ctl_wr   = reg_wr && (reg_addr == CTL_OFS);
    assign data_wr  = reg_wr && (reg_addr == DATA_OFS);
    assign data_rd  = reg_rd && (reg_addr == DATA_OFS);
    assign gcp_wr   = reg_wr && (reg_addr == GCP_OFS);
    assign data_acc = data_wr || data_rd;

    // shared by the host data port and the transmit fetch port
    function automatic logic [31:0] buffer_word(input logic [1:0] b, input logic [3:0] w);
        logic [31:0] v;
        v = 32'h0;
        if (w == WORD_HDR) begin
            v = mem_r[b][0];
            if (!port_is_dp) begin
                v[31:24] = hdr_ecc_all[b];
            end
        end else if (w <= WORD_LAST_PL) begin
            v = mem_r[b][w[2:0]];
        end else if (w == WORD_ECC) begin
            v = {ecc_all[b][3], ecc_all[b][2], ecc_all[b][1], ecc_all[b][0]};
        end else if (w == WORD_DP_ECC_LO && port_is_dp) begin
            v = {ecc_all[b][7], ecc_all[b][6], ecc_all[b][5], ecc_all[b][4]};
        end else if (w == WORD_DP_ECC_HI && port_is_dp) begin
            v = {ecc_all[b][11], ecc_all[b][10], ecc_all[b][9], ecc_all[b][8]};
        end
        // words 11..15 fall through as zero
        return v;
    endfunction

    always_comb begin
        mem_nxt       = mem_r;
        rate_nxt      = rate_r;
        gcp_en_nxt    = gcp_en_r;
        type_en_nxt   = type_en_r;
        sel_nxt       = sel_r;
        ptr_nxt       = ptr_r;
        rate_pend_nxt = rate_pend_r;
        gcp_nxt       = gcp_r;
        if (ctl_wr) begin
            gcp_en_nxt    = reg_wdata[CTL_GCP_EN_BIT];
            type_en_nxt   = reg_wdata[CTL_TYPE_LSB +: 4];
            sel_nxt       = reg_wdata[CTL_SEL_LSB +: 2];
            rate_pend_nxt = reg_wdata[CTL_RATE_LSB +: 2];
            ptr_nxt       = reg_wdata[3:0];
        end
        if (gcp_wr) begin
            gcp_nxt = reg_wdata[2:0];
        end
        if (data_acc) begin
            // 4-bit sum wraps 0xf to zero by itself
            ptr_nxt = ptr_r + 4'h1;
        end
        if (data_wr) begin
            if (ptr_r == WORD_HDR) begin
                rate_nxt[sel_r] = rate_pend_r;
                mem_nxt[sel_r][0][23:0] = reg_wdata[23:0];
                if (port_is_dp) begin
                    mem_nxt[sel_r][0][31:24] = reg_wdata[31:24];
                end
            end else if (ptr_r <= WORD_LAST_PL) begin
                mem_nxt[sel_r][ptr_r[2:0]] = reg_wdata;
            end
            // ECC and reserved words keep no storage
        end
    end

    always_comb begin
        rdata_nxt   = rdata_r;
        ack_nxt     = reg_rd || reg_wr;
        tx_data_nxt = tx_data_r;
        if (reg_rd) begin
            case (reg_addr)
                CTL_OFS: begin
                    rdata_nxt = {6'h0, gcp_en_r, type_en_r, sel_r, 1'b0, rate_r[sel_r],
                                 4'h0, BUF_SIZE_DW, 4'h0, ptr_r};
                end
                DATA_OFS: begin
                    rdata_nxt = buffer_word(sel_r, ptr_r);
                end
                GCP_OFS: begin
                    rdata_nxt = {29'h0, gcp_r};
                end
                default: begin
                    rdata_nxt = 32'h0;
                end
            endcase
        end
        if (tx_rd) begin
            tx_data_nxt = buffer_word(tx_buf, tx_word);
        end
    end

    // a new transition outranks a packet leaving in the same cycle
    always_comb begin
        mute_nxt = mute_r;
        if (gcp_sent) begin
            mute_nxt = MUTE_IDLE;
        end
        if (gcp_wr && (reg_wdata[GCP_MUTE_BIT] != gcp_r[GCP_MUTE_BIT])) begin
            mute_nxt = reg_wdata[GCP_MUTE_BIT] ? MUTE_SET_PEND : MUTE_CLR_PEND;
        end
    end

    always_comb begin
        pay_nxt = 24'h0;
        if (gcp_en_r) begin
            case (mute_r)
                MUTE_SET_PEND: pay_nxt[PAY_SET_BIT] = 1'b1;
                MUTE_CLR_PEND: pay_nxt[PAY_CLR_BIT] = 1'b1;
                default:       pay_nxt[PAY_SET_BIT] = 1'b0;
            endcase
            if (gcp_r[GCP_CD_BIT]) begin
                case (pixel_depth)
                    DEPTH_8BPC:  pay_nxt[PAY_CD_LSB +: 4] = CD_24BIT;
                    DEPTH_10BPC: pay_nxt[PAY_CD_LSB +: 4] = CD_30BIT;
                    DEPTH_12BPC: pay_nxt[PAY_CD_LSB +: 4] = CD_36BIT;
                    default:     pay_nxt[PAY_CD_LSB +: 4] = CD_NONE;
                endcase
            end
            pay_nxt[PAY_PHASE_BIT] = gcp_r[GCP_PHASE_BIT];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_r       <= '0;
            rate_r      <= '0;
            gcp_en_r    <= 1'b0;
            type_en_r   <= TYPE_EN_RST;
            sel_r       <= SEL_RST;
            ptr_r       <= PTR_RST;
            rate_pend_r <= RATE_RST;
            gcp_r       <= GCP_RST;
            mute_r      <= MUTE_IDLE;
            rdata_r     <= 32'h0;
            ack_r       <= 1'b0;
            tx_data_r   <= 32'h0;
            pay_r       <= 24'h0;
        end else begin
            mem_r       <= mem_nxt;
            rate_r      <= rate_nxt;
            gcp_en_r    <= gcp_en_nxt;
            type_en_r   <= type_en_nxt;
            sel_r       <= sel_nxt;
            ptr_r       <= ptr_nxt;
            rate_pend_r <= rate_pend_nxt;
            gcp_r       <= gcp_nxt;
            mute_r      <= mute_nxt;
            rdata_r     <= rdata_nxt;
            ack_r       <= ack_nxt;
            tx_data_r   <= tx_data_nxt;
            pay_r       <= pay_nxt;
        end
    end

    assign reg_rdata             = rdata_r;
    assign reg_ack               = ack_r;
    assign tx_data               = tx_data_r;
    assign gcp_payload           = pay_r;
    assign control_packet_enable = gcp_en_r;
    assign packet_type_enables   = type_en_r;
    assign resend_rates          = rate_r;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    ptr_advance_a: assert property (data_acc |=> ptr_r == 4'($past(ptr_r) + 4'h1))
        else $error("word pointer did not advance after a data access");
    ptr_wrap_a: assert property (data_acc && ptr_r == 4'hf |=> ptr_r == 4'h0)
        else $error("word pointer did not wrap to zero");
    data_read_a: assert property (data_rd && ptr_r >= 4'h1 && ptr_r <= WORD_LAST_PL
        |=> reg_rdata == $past(mem_r[sel_r][ptr_r[2:0]]) && reg_ack)
        else $error("data port read returned the wrong dword");
    payload_store_a: assert property (data_wr && ptr_r >= 4'h1 && ptr_r <= WORD_LAST_PL
        |=> mem_r[$past(sel_r)][$past(ptr_r[2:0])] == $past(reg_wdata))
        else $error("payload dword not stored");
    ro_words_a: assert property (data_wr && ptr_r >= WORD_ECC |=> $stable(mem_r))
        else $error("write to ECC or reserved word changed the buffer");
    hdr_lane_a: assert property (data_wr && ptr_r == WORD_HDR && !port_is_dp
        |=> mem_r[$past(sel_r)][0][31:24] == $past(mem_r[sel_r][0][31:24]))
        else $error("ECC lane of header dword was written on the TMDS port");
    rsvd_read_a: assert property (data_rd && ptr_r >= WORD_RSVD_FIRST |=> reg_rdata == 32'h0)
        else $error("reserved buffer word read non-zero");
    tmds_rsvd_a: assert property (data_rd && !port_is_dp && (ptr_r == WORD_DP_ECC_LO
        || ptr_r == WORD_DP_ECC_HI) |=> reg_rdata == 32'h0)
        else $error("DisplayPort ECC word visible on the TMDS port");
    rate_latch_a: assert property (data_wr && ptr_r == WORD_HDR
        |=> rate_r[$past(sel_r)] == $past(rate_pend_r))
        else $error("resend rate not latched on first dword write");
    cd_zero_a: assert property (!gcp_r[GCP_CD_BIT] |=> gcp_payload[15:8] == 8'h00)
        else $error("colour depth sent while indication is off");
    phase_copy_a: assert property (gcp_en_r |=> gcp_payload[PAY_PHASE_BIT] == $past(gcp_r[1]))
        else $error("default phase bit not copied into the payload");
    mute_set_a: assert property ((gcp_wr && reg_wdata[0] && !gcp_r[0] && gcp_en_r)
        ##1 !ctl_wr |=> gcp_payload[PAY_SET_BIT])
        else $error("av-mute set flag missing after rising request");

    // control packet flags, payload gating, colour depth fill, the DisplayPort header store and the transmit fetch path
    mute_clr_a: assert property ((gcp_wr && !reg_wdata[0] && gcp_r[0] && gcp_en_r)
        ##1 !ctl_wr |=> gcp_payload[PAY_CLR_BIT])
        else $error("av-mute clear flag missing after falling request");
    mute_drop_a: assert property (gcp_sent && !gcp_wr
        |-> ##2 !gcp_payload[PAY_SET_BIT] && !gcp_payload[PAY_CLR_BIT])
        else $error("av-mute flag still sent after its packet left");
    pay_off_a: assert property (!gcp_en_r |=> gcp_payload == 24'h0)
        else $error("control packet payload not zero while disabled");
    cd_fill_a: assert property (gcp_en_r && gcp_r[GCP_CD_BIT]
        && pixel_depth == DEPTH_10BPC |=> gcp_payload[PAY_CD_LSB +: 4] == CD_30BIT)
        else $error("colour depth not taken from the pixel depth");
    dp_hdr_a: assert property (data_wr && ptr_r == WORD_HDR && port_is_dp
        |=> mem_r[$past(sel_r)][0] == $past(reg_wdata))
        else $error("header dword not stored whole on DisplayPort");
    tx_fetch_a: assert property (tx_rd && tx_word >= 4'h1 && tx_word <= WORD_LAST_PL
        |=> tx_data == $past(mem_r[tx_buf][tx_word[2:0]]))
        else $error("transmit fetch returned the wrong dword");

endmodule

//--- dip_pkg.sv
package dip_pkg;

    localparam int unsigned BUF_COUNT    = 4;
    localparam int unsigned STORED_WORDS = 8;
    localparam int unsigned ECC_BYTES    = 12;

    // register byte addresses on the register port
    localparam logic [3:0] CTL_OFS  = 4'h0;
    localparam logic [3:0] DATA_OFS = 4'h4;
    localparam logic [3:0] GCP_OFS  = 4'h8;

    // control register field positions
    localparam int unsigned CTL_GCP_EN_BIT = 25;
    localparam int unsigned CTL_TYPE_LSB   = 21;
    localparam int unsigned CTL_SEL_LSB    = 19;
    localparam int unsigned CTL_RATE_LSB   = 16;
    localparam int unsigned CTL_SIZE_LSB   = 8;

    // values after reset
    localparam logic [3:0] TYPE_EN_RST = 4'h1;
    localparam logic [1:0] SEL_RST     = 2'h0;
    localparam logic [1:0] RATE_RST    = 2'h0;
    localparam logic [3:0] PTR_RST     = 4'h0;
    localparam logic [2:0] GCP_RST     = 3'h0;
    localparam logic [3:0] BUF_SIZE_DW = 4'h9;

    // payload control register bits
    localparam int unsigned GCP_CD_BIT    = 2;
    localparam int unsigned GCP_PHASE_BIT = 1;
    localparam int unsigned GCP_MUTE_BIT  = 0;

    // buffer word map
    localparam logic [3:0] WORD_HDR        = 4'h0;
    localparam logic [3:0] WORD_LAST_PL    = 4'h7;
    localparam logic [3:0] WORD_ECC        = 4'h8;
    localparam logic [3:0] WORD_DP_ECC_LO  = 4'h9;
    localparam logic [3:0] WORD_DP_ECC_HI  = 4'ha;
    localparam logic [3:0] WORD_RSVD_FIRST = 4'hb;

    // pixel depth codes and the colour depth sent for them
    localparam logic [2:0] DEPTH_8BPC  = 3'h0;
    localparam logic [2:0] DEPTH_10BPC = 3'h1;
    localparam logic [2:0] DEPTH_12BPC = 3'h3;
    localparam logic [3:0] CD_24BIT    = 4'h4;
    localparam logic [3:0] CD_30BIT    = 4'h5;
    localparam logic [3:0] CD_36BIT    = 4'h6;
    localparam logic [3:0] CD_NONE     = 4'h0;

    // bit positions inside the assembled control packet payload
    localparam int unsigned PAY_SET_BIT   = 0;
    localparam int unsigned PAY_CLR_BIT   = 4;
    localparam int unsigned PAY_CD_LSB    = 8;
    localparam int unsigned PAY_PHASE_BIT = 16;

    localparam logic [7:0] ECC_POLY = 8'h83;

    typedef enum logic [1:0] {
        MUTE_IDLE,
        MUTE_SET_PEND,
        MUTE_CLR_PEND
    } mute_state_t;

endpackage

//--- ecc_if.sv
`timescale 1ns/1ps
interface ecc_if;
    import dip_pkg::*;
    logic [STORED_WORDS-1:0][31:0] words;
    logic [ECC_BYTES-1:0][7:0]     ecc;
    logic [7:0]                    hdr_ecc;
    modport src (output words, input ecc, input hdr_ecc);
    modport gen (input words, output ecc, output hdr_ecc);
endinterface

//--- ecc_gen.sv
`timescale 1ns/1ps
module ecc_gen
    import dip_pkg::*;
(
    ecc_if.gen pkt
);

    localparam int unsigned PL_BITS = (STORED_WORDS - 1) * 32;

    // serial parity over 56 data bits, lowest bit first
    function automatic logic [7:0] bch_byte(input logic [55:0] d);
        logic [7:0] r;
        logic       fb;
        r  = 8'h00;
        fb = 1'b0;
        for (int i = 0; i < 56; i++) begin
            fb = d[i] ^ r[0];
            r  = {1'b0, r[7:1]} ^ (fb ? ECC_POLY : 8'h00);
        end
        return r;
    endfunction

    logic [PL_BITS-1:0] payload;

    assign payload     = pkt.words[STORED_WORDS-1:1];
    assign pkt.hdr_ecc = bch_byte({32'h0, pkt.words[0][23:0]});

    // four subpackets of seven payload bytes each
    for (genvar g = 0; g < 4; g++) begin : g_sub
        assign pkt.ecc[g]     = bch_byte(payload[56*g +: 56]);
        assign pkt.ecc[4 + g] = bch_byte({48'h0, pkt.words[0][8*g +: 8]});
        assign pkt.ecc[8 + g] = bch_byte(~payload[56*g +: 56]);
    end

endmodule

//--- dip_sink_model.sv
`timescale 1ns/1ps
// stands in for the transmitter side: fetches buffer words and reports sent control packets
module dip_sink_model (
    input  wire logic        sys_clk,
    output logic             tx_rd,
    output logic [1:0]       tx_buf,
    output logic [3:0]       tx_word,
    input  wire logic [31:0] tx_data,
    output logic             gcp_sent
);
    initial begin
        tx_rd    = 1'b0;
        tx_buf   = 2'h0;
        tx_word  = 4'h0;
        gcp_sent = 1'b0;
    end

    task automatic fetch(input logic [1:0] b, input logic [3:0] w, output logic [31:0] d);
        @(negedge sys_clk);
        tx_rd   = 1'b1;
        tx_buf  = b;
        tx_word = w;
        @(negedge sys_clk);
        tx_rd   = 1'b0;
        d       = tx_data;
        // released select lines show the inverse so a stale decode cannot pass
        tx_buf  = ~b;
        tx_word = ~w;
    endtask

    task automatic send_gcp();
        @(negedge sys_clk);
        gcp_sent = 1'b1;
        @(negedge sys_clk);
        gcp_sent = 1'b0;
    endtask
endmodule

//--- data_island_packet_buffer_test.sv
`timescale 1ns/1ps
module data_island_packet_buffer_test;
    import dip_pkg::*;

    logic                     sys_clk = 1'b0;
    logic                     rst_n;
    logic                     reg_wr;
    logic                     reg_rd;
    logic [3:0]               reg_addr;
    logic [31:0]              reg_wdata;
    logic [31:0]              reg_rdata;
    logic                     reg_ack;
    logic                     port_is_dp;
    logic [2:0]               pixel_depth;
    logic                     tx_rd;
    logic [1:0]               tx_buf;
    logic [3:0]               tx_word;
    logic [31:0]              tx_data;
    logic                     gcp_sent;
    logic [23:0]              gcp_payload;
    logic                     cp_en;
    logic [3:0]               type_en;
    logic [3:0][1:0]          rr;
    logic [31:0]              got;
    logic [31:0]              e8;
    int                       fail_count = 0;
    int                       checked = 0;
    int                       cycles = 0;
    localparam logic [1:0]    RT [4] = '{2'h1, 2'h2, 2'h0, 2'h1};
    localparam logic [2:0]    PD [4] = '{3'h0, 3'h1, 3'h3, 3'h2};
    localparam logic [3:0]    CD [4] = '{4'h4, 4'h5, 4'h6, 4'h0};

    always #4 sys_clk = ~sys_clk;

    data_island_packet_buffer #(.NUM_BUFS(4)) dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_ack(reg_ack), .port_is_dp(port_is_dp), .pixel_depth(pixel_depth),
        .tx_rd(tx_rd), .tx_buf(tx_buf), .tx_word(tx_word), .tx_data(tx_data),
        .gcp_sent(gcp_sent), .gcp_payload(gcp_payload),
        .control_packet_enable(cp_en), .packet_type_enables(type_en),
        .resend_rates(rr)
    );

    dip_sink_model sink (
        .sys_clk(sys_clk), .tx_rd(tx_rd), .tx_buf(tx_buf), .tx_word(tx_word),
        .tx_data(tx_data), .gcp_sent(gcp_sent)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // whole-dword strobes only, one access per pulse
    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(negedge sys_clk);
        reg_wr    = 1'b1;
        reg_addr  = a;
        reg_wdata = d;
        @(negedge sys_clk);
        reg_wr    = 1'b0;
        reg_wdata = ~d;
        check({31'h0, reg_ack}, 32'h1);
    endtask

    task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
        @(negedge sys_clk);
        reg_rd   = 1'b1;
        reg_addr = a;
        @(negedge sys_clk);
        reg_rd   = 1'b0;
        check({31'h0, reg_ack}, 32'h1);
        d = reg_rdata;
    endtask

    function automatic logic [31:0] ctl(logic g, logic [3:0] t, logic [1:0] s,
                                        logic [1:0] r, logic [3:0] p);
        return {6'h0, g, t, s, 1'b0, r, 12'h0, p};
    endfunction

    function automatic logic [31:0] pat(logic [1:0] b, logic [3:0] w);
        return {4'ha, 2'b0, b, 4'h1, w, 8'hc3, 4'h0, w};
    endfunction

    // serial parity, lowest bit first, one check byte per call
    function automatic logic [7:0] par56(logic [55:0] d);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 56; i++)
            r = {1'b0, r[7:1]} ^ (((d[i] ^ r[0]) == 1'b1) ? ECC_POLY : 8'h00);
        return r;
    endfunction

    // expected check word k (0: subpackets, 1: header bytes, 2: inverted subpackets)
    function automatic logic [31:0] ecc_word(logic [1:0] b, int k);
        logic [223:0] p;
        logic [31:0]  h;
        logic [31:0]  v;
        h = pat(b, 4'h0);
        for (int w = 1; w < 8; w++)
            p[32*(w-1) +: 32] = pat(b, 4'(w));
        for (int g = 0; g < 4; g++)
            v[8*g +: 8] = (k == 0) ? par56(p[56*g +: 56]) :
                          (k == 1) ? par56({48'h0, h[8*g +: 8]}) : par56(~p[56*g +: 56]);
        return v;
    endfunction

    task automatic settle_gcp(input logic [23:0] exp);
        repeat (2) @(negedge sys_clk);
        check({8'h0, gcp_payload}, {8'h0, exp});
    endtask

    task automatic final_report();
        $display("checks %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 6000) begin
            fail_count++;
            final_report();
        end
    end

    initial begin
        rst_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 4'h0;
        reg_wdata = 32'h0; port_is_dp = 1'b1; pixel_depth = 3'h0;
        repeat (16) @(negedge sys_clk);
        rst_n = 1'b1;
        reg_read(CTL_OFS, got);
        check(got, 32'h00200900);
        check({28'h0, type_en}, 32'h1);
        reg_read(GCP_OFS, got);
        check(got, 32'h0);
        reg_read(4'hc, got);
        check(got, 32'h0);
        $display("test reset values done");

        for (int b = 0; b < 4; b++) begin
            reg_write(CTL_OFS, ctl(1'b0, 4'h1, 2'(b), RT[b], 4'h0));
            for (int w = 0; w < 8; w++)
                reg_write(DATA_OFS, pat(2'(b), 4'(w)));
            check({30'h0, rr[b]}, {30'h0, RT[b]});
            reg_read(DATA_OFS, e8);
            reg_write(CTL_OFS, ctl(1'b0, 4'h1, 2'(b), RT[b], 4'h8));
            for (int w = 8; w < 16; w++)
                reg_write(DATA_OFS, 32'hffffffff);
            reg_read(CTL_OFS, got);
            check(got, {6'h0, 1'b0, 4'h1, 2'(b), 1'b0, RT[b], 16'h0900});
            for (int w = 0; w < 16; w++) begin
                reg_read(DATA_OFS, got);
                if (w < 8)
                    check(got, pat(2'(b), 4'(w)));
                else if (w == 8)
                    check(got, e8);
                else if (w > 10)
                    check(got, 32'h0);
                if (w >= 8 && w <= 10)
                    check(got, ecc_word(2'(b), w - 8));
            end
        end
        $display("test buffer load and readback done");

        // software loads every buffer first, then turns transmission on
        reg_write(CTL_OFS, ctl(1'b0, 4'hf, 2'h0, 2'h0, 4'h0));
        check({28'h0, type_en}, 32'hf);
        reg_read(DATA_OFS, got);
        check(got, pat(2'h0, 4'h0));
        for (int b = 0; b < 4; b++) begin
            sink.fetch(2'(b), 4'h3, got);
            check(got, pat(2'(b), 4'h3));
            sink.fetch(2'(b), 4'h0, got);
            check(got, pat(2'(b), 4'h0));
        end
        port_is_dp = 1'b0;
        reg_write(CTL_OFS, ctl(1'b0, 4'hf, 2'h2, 2'h0, 4'h9));
        reg_read(DATA_OFS, got);
        check(got, 32'h0);
        reg_read(DATA_OFS, got);
        check(got, 32'h0);
        reg_write(CTL_OFS, ctl(1'b0, 4'hf, 2'h1, RT[1], 4'h0));
        reg_write(DATA_OFS, pat(2'h1, 4'h0) ^ 32'h5a000000);
        sink.fetch(2'h1, 4'h0, got);
        check({8'h0, got[23:0]}, pat(2'h1, 4'h0) & 32'h00ffffff);
        check({24'h0, got[31:24]}, {24'h0, par56({32'h0, 24'(pat(2'h1, 4'h0))})});
        port_is_dp = 1'b1;
        sink.fetch(2'h1, 4'h0, got);
        check(got, pat(2'h1, 4'h0));
        $display("test transmit fetch done");

        reg_write(CTL_OFS, ctl(1'b1, 4'hf, 2'h0, 2'h0, 4'h0));
        check({31'h0, cp_en}, 32'h1);
        // deep colour with phase alignment met, so both bits are set
        for (int i = 0; i < 4; i++) begin
            pixel_depth = PD[i];
            reg_write(GCP_OFS, 32'h6);
            settle_gcp({7'h0, 1'b1, 4'h0, CD[i], 8'h0});
        end
        reg_read(GCP_OFS, got);
        check(got, 32'h6);
        reg_write(GCP_OFS, 32'hfffffff2);
        settle_gcp(24'h010000);
        reg_read(GCP_OFS, got);
        check(got, 32'h2);
        reg_write(GCP_OFS, 32'h1);
        settle_gcp(24'h000001);
        sink.send_gcp();
        @(negedge sys_clk);
        check({8'h0, gcp_payload}, 32'h0);
        reg_write(GCP_OFS, 32'h0);
        settle_gcp(24'h000010);
        sink.send_gcp();
        @(negedge sys_clk);
        check({8'h0, gcp_payload}, 32'h0);
        pixel_depth = 3'h1;
        reg_write(GCP_OFS, 32'h6);
        reg_write(CTL_OFS, ctl(1'b0, 4'hf, 2'h0, 2'h0, 4'h0));
        settle_gcp(24'h0);
        $display("test control packet done");
        final_report();
    end
endmodule
